// [common/trig_capture_pkg.sv]
package trig_capture_pkg;

    // ****************************************
    // Sample word layout
    // ****************************************
    localparam int DATA_W = 8;
    localparam int QUAL_W = 4;
    localparam int WORD_W = DATA_W + QUAL_W;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam logic [PTR_W-1:0] LAST_IDX = 4'hF;
    localparam logic [PTR_W-1:0] POST_COUNT = 4'hF;
    localparam int DLY_W = 17;
    localparam logic [DLY_W-1:0] DLY_MAX = 17'h1_86A0;

    // ****************************************
    // Register map (word aligned)
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PAT_CARE_OFS = 8'h04;
    localparam logic [7:0] PAT_LEVEL_OFS = 8'h08;
    localparam logic [7:0] DELAY_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] MEM_OFS = 8'h40;

    // Control fields
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_PRE_BIT = 1;
    localparam int CTRL_DLY_BIT = 2;
    localparam int CTRL_REP_BIT = 3;
    localparam int CTRL_NEG_BIT = 4;

    // Reset values
    localparam logic [WORD_W-1:0] CARE_RST = 12'h000;
    localparam logic [WORD_W-1:0] LEVEL_RST = 12'h000;
    localparam logic [DLY_W-1:0] DELAY_RST = 17'h0_0000;

    // Capture sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DELAY,
        ST_POST,
        ST_DONE
    } cap_state_e;

endpackage

// [hdl/trig_match.sv]
`timescale 1ns/1ps
module trig_match
    import trig_capture_pkg::*;
(
    // Sample
    input wire logic [trig_capture_pkg::WORD_W-1:0] word_in,
    // Pattern
    input wire logic [trig_capture_pkg::WORD_W-1:0] care_in,
    input wire logic [trig_capture_pkg::WORD_W-1:0] level_in,
    input wire logic polarity_select_in,
    // Result
    output logic hit_out
);
    // Negative logic inverts the electrical level before comparing
    wire [WORD_W-1:0] logical_word = polarity_select_in ? ~word_in : word_in;
    // Ignored bits never block; every cared bit must agree
    wire [WORD_W-1:0] bit_ok = ~care_in | ~(logical_word ^ level_in);
    assign hit_out = &bit_ok;
endmodule // trig_match

// [hdl/state_trigger_capture.sv]
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module state_trigger_capture
    import trig_capture_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    // Machine under test
    input wire logic SAMPLE_EN_IN,
    input wire logic [trig_capture_pkg::DATA_W-1:0] DATA_IN,
    input wire logic [trig_capture_pkg::QUAL_W-1:0] QUAL_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT
);
    import trig_capture_pkg::*;

    // ****************************************
    // Storage and control registers
    // ****************************************
    logic [WORD_W-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wptr_reg;
    logic [PTR_W-1:0] trig_idx_reg;
    logic [PTR_W-1:0] post_cnt_reg;
    logic [PTR_W:0] fill_reg;
    logic [DLY_W-1:0] dly_cnt_reg;
    cap_state_e state_reg;
    logic [4:0] ctrl_reg;
    logic [WORD_W-1:0] care_reg;
    logic [WORD_W-1:0] level_reg;
    logic [DLY_W-1:0] delay_reg;
    logic arm_pulse;
    logic trig_hit;

    wire [WORD_W-1:0] sample_word = {QUAL_IN, DATA_IN};
    wire pre_mode = ctrl_reg[CTRL_PRE_BIT];
    wire dly_mode = ctrl_reg[CTRL_DLY_BIT];
    wire rep_mode = ctrl_reg[CTRL_REP_BIT];

    // ****************************************
    // Trigger comparator
    // ****************************************
    trig_match u_match (
        .word_in(sample_word),
        .care_in(care_reg),
        .level_in(level_reg),
        .polarity_select_in(ctrl_reg[CTRL_NEG_BIT]),
        .hit_out(trig_hit)
    );

    // ****************************************
    // AHB-Lite address phase capture
    // ****************************************
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    wire bus_go = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    wire wr_ctrl = wr_pend_reg && addr_reg == CTRL_OFS;
    assign arm_pulse = wr_ctrl && HWDATA_IN[CTRL_ARM_BIT];

    // Zero wait states, always OKAY
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    // Address latch
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= bus_go && HWRITE_IN;
            addr_reg <= HADDR_IN[7:0];
        end
    end

    // Register writes; arm bit is a strobe, not stored
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            ctrl_reg <= 5'h00;
            care_reg <= CARE_RST;
            level_reg <= LEVEL_RST;
            delay_reg <= DELAY_RST;
        end else if (wr_pend_reg) begin
            if (addr_reg == CTRL_OFS)
                ctrl_reg <= {HWDATA_IN[4:1], 1'b0};
            if (addr_reg == PAT_CARE_OFS)
                care_reg <= HWDATA_IN[WORD_W-1:0];
            if (addr_reg == PAT_LEVEL_OFS)
                level_reg <= HWDATA_IN[WORD_W-1:0];
            if (addr_reg == DELAY_OFS)
                delay_reg <= HWDATA_IN[DLY_W-1:0];
        end
    end

    // ****************************************
    // Read mux: memory window plus registers
    // ****************************************
    // Status word: busy b0, done b1, fill b7:3, trigger position b19:16
    // Position is relative to the oldest entry, matching the memory window
    // order, so software never needs to know the physical write pointer
    wire [31:0] status_word = {8'h00, 4'h0, trig_idx_reg - wptr_reg, 8'h00,
                               fill_reg, 1'b0, (state_reg == ST_DONE),
                               (state_reg != ST_IDLE && state_reg != ST_DONE)};

    // Read data registered at the address phase, valid in data phase
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN)
            HRDATA_OUT <= 32'h0000_0000;
        else if (bus_go && !HWRITE_IN)
            HRDATA_OUT <= rd_mux_next(HADDR_IN[7:0]);
    end

    function automatic logic [31:0] rd_mux_next(input logic [7:0] a);
        logic [PTR_W-1:0] p;
        p = wptr_reg + a[5:2];
        rd_mux_next = 32'h0000_0000;
        if (a[7:6] == MEM_OFS[7:6])
            rd_mux_next = {20'h0_0000, mem_reg[p]};
        else if (a == CTRL_OFS)
            rd_mux_next = {27'h000_0000, ctrl_reg};
        else if (a == PAT_CARE_OFS)
            rd_mux_next = {20'h0_0000, care_reg};
        else if (a == PAT_LEVEL_OFS)
            rd_mux_next = {20'h0_0000, level_reg};
        else if (a == DELAY_OFS)
            rd_mux_next = {15'h0000, delay_reg};
        else if (a == STATUS_OFS)
            rd_mux_next = status_word;
    endfunction

    // ****************************************
    // Capture sequencer
    // ****************************************
    wire sampling = SAMPLE_EN_IN && (state_reg == ST_WAIT || state_reg == ST_POST);
    wire fire = SAMPLE_EN_IN && state_reg == ST_WAIT && trig_hit;
    wire full = fill_reg[PTR_W];
    wire cap_end = SAMPLE_EN_IN && state_reg == ST_POST && post_cnt_reg == 4'h0;
    wire pre_done = fire && pre_mode && !dly_mode;

    // Sample memory writes
    always_ff @(posedge SYS_CLK_IN) begin
        if (sampling && !(state_reg == ST_WAIT && !pre_mode && !fire))
            mem_reg[wptr_reg] <= sample_word;
    end

    // Sequencing: pointers, counters, state
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            state_reg <= ST_IDLE;
            wptr_reg <= 4'h0;
            trig_idx_reg <= 4'h0;
            post_cnt_reg <= 4'h0;
            fill_reg <= 5'h00;
            dly_cnt_reg <= 17'h0_0000;
        end else if (arm_pulse) begin
            state_reg <= ST_WAIT;
            wptr_reg <= 4'h0;
            fill_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_DONE: ;
                ST_WAIT: begin
                    if (SAMPLE_EN_IN && pre_mode && !dly_mode) begin
                        wptr_reg <= wptr_reg + 4'h1;
                        if (!full)
                            fill_reg <= fill_reg + 5'h01;
                    end
                    if (fire) begin
                        trig_idx_reg <= wptr_reg;
                        if (dly_mode) begin
                            dly_cnt_reg <= delay_reg;
                            state_reg <= ST_DELAY;
                        end else if (pre_mode) begin
                            wptr_reg <= wptr_reg + 4'h1;
                            fill_reg <= full ? fill_reg : fill_reg + 5'h01;
                            state_reg <= rep_mode ? ST_WAIT : ST_DONE;
                        end else begin
                            wptr_reg <= wptr_reg + 4'h1;
                            fill_reg <= 5'h01;
                            post_cnt_reg <= POST_COUNT - 4'h1;
                            state_reg <= ST_POST;
                        end
                    end
                end
                ST_DELAY: begin
                    if (SAMPLE_EN_IN) begin
                        if (dly_cnt_reg == 17'h0_0000) begin
                            state_reg <= ST_POST;
                            post_cnt_reg <= LAST_IDX;
                            wptr_reg <= 4'h0;
                            fill_reg <= 5'h00;
                        end else begin
                            dly_cnt_reg <= dly_cnt_reg - 17'h0_0001;
                        end
                    end
                end
                ST_POST: begin
                    if (SAMPLE_EN_IN) begin
                        wptr_reg <= wptr_reg + 4'h1;
                        fill_reg <= fill_reg + 5'h01;
                        post_cnt_reg <= post_cnt_reg - 4'h1;
                        if (cap_end)
                            state_reg <= rep_mode ? ST_WAIT : ST_DONE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_PRE_FREEZE: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        pre_done && !rep_mode && !arm_pulse |=> state_reg == ST_DONE)
        else $error("pre-trigger capture did not freeze");
    AST_POST_LEN: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        cap_end && !arm_pulse |=> fill_reg == 5'h10)
        else $error("post capture length not 16");
    AST_SINGLE_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        state_reg == ST_DONE && !arm_pulse |=> $stable(wptr_reg) && state_reg == ST_DONE)
        else $error("single shot did not hold");
    AST_REARM: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        cap_end && rep_mode && !arm_pulse |=> state_reg == ST_WAIT)
        else $error("repetitive mode did not rearm");
    AST_DELAY_START: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        fire && dly_mode && !arm_pulse |=> state_reg == ST_DELAY && dly_cnt_reg == delay_reg)
        else $error("delay counter not loaded");
    AST_TRIG_MARK: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        fire && !dly_mode && !arm_pulse |=> trig_idx_reg == $past(wptr_reg))
        else $error("trigger entry not marked");
    AST_IGNORE_ALL: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        care_reg == 12'h000 |-> trig_hit)
        else $error("ignored bits blocked a match");
    AST_POS_MATCH: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !ctrl_reg[CTRL_NEG_BIT] && care_reg == 12'hFFF |-> trig_hit == (sample_word == level_reg))
        else $error("positive polarity match wrong");
    AST_NEG_MATCH: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
        ctrl_reg[CTRL_NEG_BIT] && care_reg == 12'hFFF |-> trig_hit == (~sample_word == level_reg))
        else $error("negative polarity match wrong");
endmodule // state_trigger_capture

// [verif/mut_model.sv]
`timescale 1ns/1ps
// ****************************************
// Machine under test: counting state stream
// ****************************************
module mut_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control from bench
    input wire logic run_in,
    input wire logic slow_in,
    // Sample stream
    output logic sample_en_out,
    output logic [7:0] data_out,
    output logic [3:0] qual_out,
    output logic [11:0] count_out
);
    logic [11:0] cnt_reg;
    logic en_reg;
    logic phase_reg;

    // Word advances once per strobe; slow mode strobes every other cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_reg <= 12'h000;
            en_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
            if (en_reg) begin
                cnt_reg <= cnt_reg + 12'h001;
            end
            en_reg <= run_in && (!slow_in || phase_reg);
        end
    end

    // Off-strobe cycles show the inverse, so stale words cannot match by luck
    assign {qual_out, data_out} = en_reg ? cnt_reg : ~cnt_reg;
    assign sample_en_out = en_reg;
    assign count_out = cnt_reg;
endmodule // mut_model

// [verif/state_trigger_capture_tb.sv]
`timescale 1ns/1ps
module state_trigger_capture_tb;
    import trig_capture_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic run = 1'b0;
    logic slow = 1'b0;
    wire logic en;
    wire logic [7:0] data;
    wire logic [3:0] qual;
    wire logic [11:0] cnt;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [11:0] t;
    logic [11:0] t_old;

    // ****************************************
    // Clock, design and stream source
    // ****************************************
    always #2.5 clk = ~clk;

    state_trigger_capture DUT (.SYS_CLK_IN(clk), .SRST_IN(rst), .SAMPLE_EN_IN(en),
        .DATA_IN(data), .QUAL_IN(qual), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp));

    mut_model mut (.clk_in(clk), .rst_in(rst), .run_in(run), .slow_in(slow),
        .sample_en_out(en), .data_out(data), .qual_out(qual), .count_out(cnt));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Entered right after a rising edge; hold the phase until hready
    task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        check({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb_xfer(a, 1'b1, d, q);
    endtask

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] q);
        ahb_xfer(a, 1'b0, 32'h0000_0000, q);
    endtask

    task automatic check_mem(input logic [11:0] base);
        for (int i = 0; i < DEPTH; i++) begin
            ahb_read(MEM_OFS + 8'(4 * i), rd);
            check(rd, {20'h0_0000, base + 12'(i)});
        end
    endtask

    // Stop the stream, aim the pattern 20 words ahead, arm and run to done
    task automatic cap(input logic [31:0] ctrl, input logic [11:0] care, input logic [11:0] lx,
                       input logic neg, input logic [11:0] ofs, input logic [3:0] pos);
        int n;
        run <= 1'b0;
        repeat (3) @(posedge clk);
        t = cnt + 12'h014;
        ahb_write(PAT_CARE_OFS, {20'h0_0000, care});
        ahb_write(PAT_LEVEL_OFS, {20'h0_0000, (neg ? ~t : t) ^ lx});
        ahb_write(CTRL_OFS, ctrl | 32'h0000_0001);
        run <= 1'b1;
        n = 0;
        rd = 32'h0000_0000;
        // Repetitive mode never parks in done; a full window marks the end
        while (rd[1] !== 1'b1 && !(ctrl[CTRL_REP_BIT] && rd[7:3] === 5'h10) && n < 300) begin
            ahb_read(STATUS_OFS, rd);
            n++;
        end
        run <= 1'b0;
        check({31'h0000_0000, n < 300}, 32'h0000_0001);
        check({27'h000_0000, rd[7:3]}, 32'h0000_0010);
        if (!ctrl[CTRL_DLY_BIT]) begin
            check({28'h000_0000, rd[19:16]}, {28'h000_0000, pos});
        end
        check_mem(t + ofs);
    endtask

    task automatic wait_cnt(input logic [11:0] target);
        int n;
        n = 0;
        while (cnt !== target && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check({31'h0000_0000, n < 3000}, 32'h0000_0001);
    endtask

    // Capture once, retarget without rearming, see whether memory moves on
    task automatic persist(input logic rep);
        cap(32'(rep) << CTRL_REP_BIT, 12'hFFF, 12'h000, 1'b0, 12'h000, 4'h0);
        t_old = t;
        repeat (3) @(posedge clk);
        t = cnt + 12'h014;
        ahb_write(PAT_LEVEL_OFS, {20'h0_0000, t});
        run <= 1'b1;
        wait_cnt(t + 12'h028);
        run <= 1'b0;
        ahb_read(MEM_OFS, rd);
        check(rd, {20'h0_0000, rep ? t : t_old});
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ahb_read(DELAY_OFS, rd);
        check(rd, {15'h0000, DELAY_RST});
        ahb_write(8'h20, 32'hFFFF_FFFF);
        ahb_read(8'h20, rd);
        check(rd, 32'h0000_0000);
        ahb_write(DELAY_OFS, {15'h0000, DLY_MAX});
        ahb_read(DELAY_OFS, rd);
        check(rd, {15'h0000, DLY_MAX});
        ahb_write(DELAY_OFS, 32'h0000_0005);
        cap(32'h0000_0000, 12'hFFF, 12'h000, 1'b0, 12'h000, 4'h0);
        cap(32'h0000_0001 << CTRL_PRE_BIT, 12'hFFF, 12'h000, 1'b0, 12'hFF1, 4'hF);
        slow <= 1'b1;
        cap(32'h0000_0001 << CTRL_DLY_BIT, 12'hFFF, 12'h000, 1'b0, 12'h007, 4'h0);
        slow <= 1'b0;
        cap(32'h0000_0001 << CTRL_NEG_BIT, 12'hFFF, 12'h000, 1'b1, 12'h000, 4'h0);
        cap(32'h0000_0000, 12'h0FF, 12'hF00, 1'b0, 12'h000, 4'h0);
        persist(1'b0);
        persist(1'b1);
        test_done();
    end

    // Hang guard, well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule // state_trigger_capture_tb
